// ---- verilog/qbus_ctl_pkg.sv ----
// shared constants and carriers for the bus interface control and status block
package qbus_ctl_pkg;
  localparam logic [31:0] system_configuration_addr = 32'h2008_0000;
  localparam logic [31:0] dma_system_error_flags_addr = 32'h2008_0004;
  localparam logic [31:0] translation_map_base_addr = 32'h2008_0010;
  // field positions
  localparam int cfg_power_good_bit = 15;
  localparam int cfg_halt_enable_bit = 14;
  localparam int cfg_aux_mode_bit = 10;
  localparam int cfg_dcok_action_bit = 7;
  localparam int err_halt_bit = 15;
  localparam int err_dcok_bit = 14;
  localparam int err_no_reply_bit = 7;
  localparam int err_parity_bit = 5;
  localparam int err_memory_bit = 4;
  localparam int err_lost_bit = 3;
  localparam int err_no_grant_bit = 2;
  localparam logic [31:0] map_base_mask = 32'h1fff_8000;
  localparam logic [15:0] err_valid_mask = 16'hc0bc;
  localparam logic [15:0] err_reset_value = 16'h0000;
  localparam logic [1:0] cfg_reset_value = 2'h0;
  // interrupt priority levels
  localparam logic [4:0] ipl_onboard = 5'h14;
  localparam logic [4:0] ipl_timer_ack = 5'h16;
  localparam logic [4:0] ipl_bus_ack = 5'h17;
  localparam logic [4:0] ipl_br4 = 5'h14;
  localparam logic [4:0] ipl_br5 = 5'h15;
  localparam logic [4:0] ipl_br6 = 5'h16;
  localparam logic [4:0] ipl_br7 = 5'h17;
  localparam logic [4:0] ipl_reset_value = 5'h1f;
  // timing
  localparam int clk_mhz = 125;
  localparam int no_reply_us = 10;
  localparam int no_grant_ms = 10;
  localparam int no_reply_cycles = no_reply_us * clk_mhz;
  localparam int no_grant_cycles = no_grant_ms * 1000 * clk_mhz;
  localparam int cache_entries = 16;
  localparam int halt_code_board_reset = 3;
  localparam int halt_code_soft = 2;
  typedef struct packed {
    logic valid;
    logic write;
    logic [31:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } reg_req_t;
  typedef struct packed {
    logic ack;
    logic error;
    logic [31:0] rdata;
  } reg_rsp_t;
  typedef enum logic [1:0] {
    cyc_demand = 2'b00,
    cyc_iack = 2'b01,
    cyc_request_read = 2'b10
  } cyc_kind_t;
endpackage : qbus_ctl_pkg

// ---- verilog/cycle_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
// counts while armed and flags once the limit is reached
module cycle_timer #(
  parameter int limit = 1250
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic armed,
  output logic expired
);
  logic [23:0] count_reg;

  // restarts whenever disarmed so each wait is measured from its own start
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= 24'h000000;
    end else if (!armed) begin
      count_reg <= 24'h000000;
    end else if (count_reg != 24'(limit)) begin
      count_reg <= count_reg + 24'h000001;
    end
  end

  assign expired = armed && (count_reg == 24'(limit - 1));
endmodule : cycle_timer
`default_nettype wire

// ---- verilog/irq_arbiter.sv ----
`timescale 1ns/1ps
`default_nettype none
// interrupt priority selection and acknowledge priority setting
module irq_arbiter
  import qbus_ctl_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [3:0] bus_request,
  input wire logic onboard_request,
  input wire logic timer_request,
  input wire logic [4:0] cpu_ipl,
  input wire logic ack_taken,
  output logic [2:0] grant_sel,
  output logic grant_valid,
  output logic [4:0] new_ipl
);
  // grant_sel: 1 timer, 2 onboard, 4..7 bus level br4..br7
  always_comb begin
    grant_sel = 3'h0;
    grant_valid = 1'b0;
    if (bus_request[3] && cpu_ipl < ipl_br7) begin
      grant_sel = 3'h7;
      grant_valid = 1'b1;
    end else if (timer_request && cpu_ipl < ipl_timer_ack) begin // RQ4
      grant_sel = 3'h1;
      grant_valid = 1'b1;
    end else if (bus_request[2] && cpu_ipl < ipl_br6) begin
      grant_sel = 3'h6;
      grant_valid = 1'b1;
    end else if (bus_request[1] && cpu_ipl < ipl_br5) begin
      grant_sel = 3'h5;
      grant_valid = 1'b1;
    end else if (onboard_request && cpu_ipl < ipl_onboard) begin // RQ2
      grant_sel = 3'h2;
      grant_valid = 1'b1;
    end else if (bus_request[0] && cpu_ipl < ipl_br4) begin
      grant_sel = 3'h4;
      grant_valid = 1'b1;
    end
  end

  // priority after acknowledge, held until the next one
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      new_ipl <= ipl_reset_value;
    end else if (ack_taken && grant_valid) begin
      if (grant_sel[2]) begin
        new_ipl <= ipl_bus_ack; // RQ3
      end else if (grant_sel == 3'h1) begin
        new_ipl <= ipl_timer_ack; // RQ4
      end else begin
        new_ipl <= ipl_onboard;
      end
    end
  end
endmodule : irq_arbiter
`default_nettype wire

// ---- verilog/qbus_interface_control_status.sv ----
// bus interface control and status registers, interrupt handling and error logging
// Function
// RQ1: acknowledge bus requests with din then iak
// RQ2: onboard sources at 14 beat br4
// RQ3: bus acknowledge raises priority to 17
// RQ4: timer above br6, acknowledge sets 16
// RQ5: firmware puts aligned map in top memory
// RQ6: software reaches map only through window
// RQ7: map base longword only, unused bits zero
// RQ8: map base write invalidates whole cache
// RQ9: map base untouched by bus init
// RQ10: configuration bytes writable, cleared on reset
// RQ11: power good bit follows bpok line
// RQ12: halt enable lets bhalt halt, flag it
// RQ13: auxiliary bit always reads zero
// RQ14: dcok negation: board reset or soft halt
// RQ15: error flags set on event, one clears
// RQ16: halt detected flag set and cleared
// RQ17: dcok negation flag when action bit set
// RQ18: no reply within 10 us flag
// RQ19: demand read parity error flag
// RQ20: local memory error flag for external reads
// RQ21: lost error when address flag already set
// RQ22: no grant within 10 ms flag
`timescale 1ns/1ps
`default_nettype none
module qbus_interface_control_status
  import qbus_ctl_pkg::*;
#(
  parameter int no_grant_limit = no_grant_cycles
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire qbus_ctl_pkg::reg_req_t reg_req,
  output qbus_ctl_pkg::reg_rsp_t reg_rsp,
  input wire logic io_reset_register,
  input wire logic bus_bpok,
  input wire logic bus_dcok,
  input wire logic bus_bhalt,
  input wire logic [3:0] bus_request,
  input wire logic onboard_request,
  input wire logic timer_request,
  input wire logic [4:0] cpu_ipl,
  input wire logic iack_start,
  input wire logic bus_rply,
  input wire logic [8:0] bus_vector,
  output logic bus_din,
  output logic bus_iak,
  output logic iack_done,
  output logic [8:0] iack_vector,
  output logic [2:0] iack_source,
  output logic [4:0] ipl_after_ack,
  input wire logic cyc_start,
  input wire qbus_ctl_pkg::cyc_kind_t cyc_kind,
  input wire logic cyc_read,
  input wire logic bus_grant,
  input wire logic cyc_reply,
  input wire logic cyc_parity_err,
  input wire logic local_mem_error,
  output logic cpu_halt,
  output logic board_reset,
  output logic soft_halt_line,
  output logic [1:0] halt_code,
  output logic cache_invalidate_all,
  output logic mem_error_doorbell,
  output logic [31:0] map_base_out
);
  typedef enum logic [1:0] {
    iack_idle = 2'b00,
    iack_din = 2'b01,
    iack_wait = 2'b10
  } iack_state_t;
  typedef enum logic [1:0] {
    cyc_idle = 2'b00,
    cyc_wait_grant = 2'b01,
    cyc_wait_reply = 2'b10
  } cyc_state_t;

  logic rst_sync1_reg;
  logic rst_sync2_reg;
  logic rst_n;
  logic [1:0] cfg_opts_reg;
  logic power_good_flag_reg;
  logic [15:0] err_reg;
  logic [31:0] map_base_reg;
  logic dcok_prev_reg;
  logic dcok_fall;
  logic [31:0] wmask;
  logic hit_cfg;
  logic hit_err;
  logic hit_map;
  logic wr;
  logic [15:0] err_set;
  logic [15:0] err_clear;
  iack_state_t iack_state_reg;
  logic [2:0] iack_sel_reg;
  logic [2:0] grant_sel;
  logic grant_valid;
  cyc_state_t cyc_state_reg;
  logic cyc_demand_reg;
  logic cyc_read_reg;
  logic grant_expired;
  logic reply_expired;
  logic [15:0] addr_flags;
  logic halt_enable;
  logic dcok_action;

  // reset release through two flops
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rst_sync1_reg <= 1'b0;
      rst_sync2_reg <= 1'b0;
    end else begin
      rst_sync1_reg <= 1'b1;
      rst_sync2_reg <= rst_sync1_reg;
    end
  end
  assign rst_n = rst_sync2_reg;

  // byte lane mask and decode
  assign wmask = {{8{reg_req.be[3]}}, {8{reg_req.be[2]}}, {8{reg_req.be[1]}}, {8{reg_req.be[0]}}};
  assign hit_cfg = reg_req.addr == system_configuration_addr;
  assign hit_err = reg_req.addr == dma_system_error_flags_addr;
  assign hit_map = reg_req.addr == translation_map_base_addr;
  assign wr = reg_req.valid && reg_req.write;
  assign halt_enable = cfg_opts_reg[1];
  assign dcok_action = cfg_opts_reg[0];

  // dcok negation edge; bus inputs taken as synchronous
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dcok_prev_reg <= 1'b1;
    end else begin
      dcok_prev_reg <= bus_dcok;
    end
  end
  assign dcok_fall = dcok_prev_reg && !bus_dcok;

  // option fields: halt enable and dcok action
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_opts_reg <= cfg_reset_value; // RQ10
    end else if (dcok_fall && !dcok_action) begin
      cfg_opts_reg <= cfg_reset_value; // RQ10
    end else if (wr && hit_cfg) begin
      if (wmask[cfg_halt_enable_bit]) begin // RQ10
        cfg_opts_reg[1] <= reg_req.wdata[cfg_halt_enable_bit];
      end
      if (wmask[cfg_dcok_action_bit]) begin
        cfg_opts_reg[0] <= reg_req.wdata[cfg_dcok_action_bit];
      end
    end
  end

  // power good mirrors bpok; write-protected
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      power_good_flag_reg <= 1'b0;
    end else if (dcok_fall) begin
      power_good_flag_reg <= 1'b0; // RQ11
    end else begin
      power_good_flag_reg <= bus_bpok; // RQ11
    end
  end

  // map base: held across bus init, cleared only at our own reset for determinism
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      map_base_reg <= 32'h0000_0000; // RQ9
    end else if (wr && hit_map && reg_req.be == 4'hf) begin
      map_base_reg <= reg_req.wdata & map_base_mask; // RQ7
    end
  end
  assign map_base_out = map_base_reg;

  // cache flush pulse on any accepted map base write
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cache_invalidate_all <= 1'b0;
    end else begin
      cache_invalidate_all <= (wr && hit_map && reg_req.be == 4'hf) || io_reset_register
                              || dcok_fall; // RQ8
    end
  end

  // register read path and answer, one cycle after request
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rsp <= '0;
    end else begin
      reg_rsp.ack <= reg_req.valid;
      reg_rsp.error <= reg_req.valid && ((hit_map && reg_req.be != 4'hf)
                       || !(hit_cfg || hit_err || hit_map)); // RQ7
      reg_rsp.rdata <= 32'h0000_0000;
      if (reg_req.valid && !reg_req.write) begin
        if (hit_cfg) begin
          reg_rsp.rdata <= {16'h0000, power_good_flag_reg, halt_enable, 3'h0,
                            1'b0, 2'h0, dcok_action, 7'h00}; // RQ13
        end else if (hit_err) begin
          reg_rsp.rdata <= {16'h0000, err_reg}; // RQ15
        end else if (hit_map && reg_req.be == 4'hf) begin
          reg_rsp.rdata <= map_base_reg; // RQ7
        end
      end
    end
  end

  // interrupt acknowledge sequence
  irq_arbiter u_arb (
    .mclk(mclk),
    .rst_n(rst_n),
    .bus_request(bus_request),
    .onboard_request(onboard_request),
    .timer_request(timer_request),
    .cpu_ipl(cpu_ipl),
    .ack_taken(iack_start && iack_state_reg == iack_idle),
    .grant_sel(grant_sel),
    .grant_valid(grant_valid),
    .new_ipl(ipl_after_ack)
  );

  // only bus levels go on the bus; internal sources finish in one cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      iack_state_reg <= iack_idle;
      iack_sel_reg <= 3'h0;
      bus_din <= 1'b0;
      bus_iak <= 1'b0;
      iack_done <= 1'b0;
      iack_vector <= 9'h000;
      iack_source <= 3'h0;
    end else begin
      iack_done <= 1'b0;
      case (iack_state_reg)
        iack_idle: begin
          if (iack_start && grant_valid) begin
            iack_sel_reg <= grant_sel;
            if (grant_sel[2]) begin
              bus_din <= 1'b1; // RQ1
              iack_state_reg <= iack_din;
            end else begin
              iack_done <= 1'b1;
              iack_source <= grant_sel;
              iack_vector <= 9'h000;
            end
          end
        end
        iack_din: begin
          bus_iak <= 1'b1; // RQ1
          iack_state_reg <= iack_wait;
        end
        iack_wait: begin
          if (bus_rply) begin
            bus_din <= 1'b0;
            bus_iak <= 1'b0;
            iack_done <= 1'b1;
            iack_vector <= bus_vector; // RQ1
            iack_source <= iack_sel_reg;
            iack_state_reg <= iack_idle;
          end
        end
        default: begin
          iack_state_reg <= iack_idle;
        end
      endcase
    end
  end

  // processor bus cycle tracking for timeouts
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cyc_state_reg <= cyc_idle;
      cyc_demand_reg <= 1'b0;
      cyc_read_reg <= 1'b0;
    end else begin
      case (cyc_state_reg)
        cyc_idle: begin
          if (cyc_start) begin
            cyc_demand_reg <= cyc_kind == cyc_demand;
            cyc_read_reg <= cyc_read;
            cyc_state_reg <= cyc_wait_grant;
          end
        end
        cyc_wait_grant: begin
          if (bus_grant) begin
            cyc_state_reg <= cyc_wait_reply;
          end else if (grant_expired) begin
            cyc_state_reg <= cyc_idle;
          end
        end
        cyc_wait_reply: begin
          if (cyc_reply || reply_expired) begin
            cyc_state_reg <= cyc_idle;
          end
        end
        default: begin
          cyc_state_reg <= cyc_idle;
        end
      endcase
    end
  end

  cycle_timer #(.limit(no_grant_limit)) u_grant_timer (
    .mclk(mclk),
    .rst_n(rst_n),
    .armed(cyc_state_reg == cyc_wait_grant && !bus_grant),
    .expired(grant_expired)
  );

  cycle_timer #(.limit(no_reply_cycles)) u_reply_timer (
    .mclk(mclk),
    .rst_n(rst_n),
    .armed(cyc_state_reg == cyc_wait_reply && !cyc_reply),
    .expired(reply_expired)
  );

  // error flag events
  always_comb begin
    err_set = 16'h0000;
    err_set[err_halt_bit] = bus_bhalt && halt_enable; // RQ16
    err_set[err_dcok_bit] = dcok_fall && dcok_action; // RQ17
    err_set[err_no_reply_bit] = reply_expired && cyc_demand_reg; // RQ18
    err_set[err_parity_bit] = cyc_state_reg == cyc_wait_reply && cyc_reply
                              && cyc_parity_err && cyc_read_reg && cyc_demand_reg; // RQ19
    err_set[err_memory_bit] = local_mem_error; // RQ20
    err_set[err_no_grant_bit] = grant_expired && cyc_demand_reg; // RQ22
    addr_flags = err_reg & 16'h00b1;
    // RQ21
    err_set[err_lost_bit] = (addr_flags != 16'h0000) && ((err_set & 16'h00b1) != 16'h0000);
  end

  assign err_clear = (wr && hit_err) ? (reg_req.wdata[15:0] & wmask[15:0]) : 16'h0000;

  // sticky flags; a new event beats a same-cycle clear
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      err_reg <= err_reset_value;
    end else if (io_reset_register || (dcok_fall && !dcok_action)) begin
      err_reg <= err_reset_value; // RQ16
    end else begin
      err_reg <= ((err_reg & ~err_clear) | err_set) & err_valid_mask; // RQ15
    end
  end
  assign mem_error_doorbell = err_reg[err_memory_bit]; // RQ20

  // halt and dcok responses
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_halt <= 1'b0;
      board_reset <= 1'b0;
      soft_halt_line <= 1'b0;
      halt_code <= 2'h0;
    end else begin
      cpu_halt <= bus_bhalt && halt_enable; // RQ12
      board_reset <= dcok_fall && !dcok_action; // RQ14
      soft_halt_line <= dcok_fall && dcok_action; // RQ14
      if (dcok_fall) begin
        halt_code <= dcok_action ? 2'(halt_code_soft) : 2'(halt_code_board_reset); // RQ14
      end
    end
  end
endmodule : qbus_interface_control_status
`default_nettype wire

// ---- bench/qbus_ctl_properties.sv ----
// port assertions for the bus interface control and status block
`timescale 1ns/1ps
`default_nettype none
module qbus_ctl_props
  import qbus_ctl_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire qbus_ctl_pkg::reg_req_t reg_req,
  input wire qbus_ctl_pkg::reg_rsp_t reg_rsp,
  input wire logic bus_dcok,
  input wire logic local_mem_error,
  input wire logic bus_din,
  input wire logic bus_iak,
  input wire logic iack_done,
  input wire logic [2:0] iack_source,
  input wire logic [4:0] ipl_after_ack,
  input wire logic board_reset,
  input wire logic soft_halt_line,
  input wire logic [1:0] halt_code,
  input wire logic cache_invalidate_all,
  input wire logic mem_error_doorbell,
  input wire logic [31:0] map_base_out
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // map base requests
  logic map_hit;
  logic map_full;
  assign map_hit = reg_req.valid && reg_req.addr == translation_map_base_addr;
  assign map_full = map_hit && reg_req.write && reg_req.be == 4'hf;
  // data-in first, then acknowledge
  sequence iack_open;
    $rose(bus_din) && !bus_iak;
  endsequence
  sequence iack_addr;
    bus_din && bus_iak;
  endsequence
  a_ack_next: assert property (reg_req.valid |=> reg_rsp.ack)
    else $error("no answer");
  a_ack_cause: assert property (reg_rsp.ack |-> $past(reg_req.valid))
    else $error("stray answer");
  a_map_flush: assert property (map_full |=> cache_invalidate_all)
    else $error("no flush");
  a_map_zero: assert property ((map_base_out & ~map_base_mask) == 32'h0)
    else $error("map bits set");
  a_map_refuse: assert property (map_hit && reg_req.be != 4'hf |=> reg_rsp.error)
    else $error("partial map ok");
  a_din_iak: assert property (iack_open |=> iack_addr)
    else $error("iack order");
  a_bus_ipl: assert property (iack_done && iack_source[2] |-> ipl_after_ack == ipl_bus_ack)
    else $error("bus ipl");
  a_timer_ipl: assert property (iack_done && iack_source == 3'h1 |-> ipl_after_ack == ipl_timer_ack)
    else $error("timer ipl");
  a_board_code: assert property (board_reset |-> halt_code == 2'h3)
    else $error("code 3");
  a_halt_lines: assert property (!(board_reset && soft_halt_line))
    else $error("two actions");
  a_dcok_react: assert property ($fell(bus_dcok) |-> ##[1:4] (board_reset || soft_halt_line))
    else $error("no dcok action");
  a_doorbell: assert property (local_mem_error |-> ##[1:3] mem_error_doorbell)
    else $error("no doorbell");
endmodule : qbus_ctl_props
`default_nettype wire

// ---- bench/bus_partner.sv ----
// far side model: interrupting device, arbiter grant and slave reply
`timescale 1ns/1ps
`default_nettype none
module bus_partner (
  input wire logic mclk,
  input wire logic bus_din,
  input wire logic bus_iak,
  input wire logic cyc_start,
  input wire logic [15:0] grant_wait,
  input wire logic [15:0] reply_wait,
  input wire logic bad_parity,
  input wire logic [8:0] vector,
  output logic bus_rply,
  output logic [8:0] bus_vector,
  output logic bus_grant,
  output logic cyc_reply,
  output logic cyc_parity_err
);
  logic rply_q = 1'b0;
  logic [8:0] vec_q = 9'h0;
  logic grant_q = 1'b0;
  logic reply_q = 1'b0;
  logic perr_q = 1'b0;
  logic busy = 1'b0;
  int cnt = 0;
  assign bus_rply = rply_q;
  assign bus_vector = vec_q;
  assign bus_grant = grant_q;
  assign cyc_reply = reply_q;
  assign cyc_parity_err = perr_q;
  // vector while acknowledged; released lines invert
  always @(posedge mclk) begin
    rply_q <= bus_din && bus_iak;
    vec_q <= (bus_din && bus_iak) ? vector : ~vec_q;
  end
  // set delays; zero means never
  always @(posedge mclk) begin
    reply_q <= 1'b0;
    perr_q <= 1'b0;
    if (cyc_start) begin
      cnt <= 0;
      busy <= 1'b1;
      grant_q <= 1'b0;
    end else if (busy) begin
      cnt <= cnt + 1;
      if (grant_wait != 0 && cnt == grant_wait) grant_q <= 1'b1;
      if (reply_wait != 0 && cnt == grant_wait + reply_wait) begin
        reply_q <= 1'b1;
        perr_q <= bad_parity;
        busy <= 1'b0;
      end
    end else begin
      grant_q <= 1'b0;
    end
  end
endmodule : bus_partner
`default_nettype wire

// ---- bench/testbench.sv ----
// self-checking bench for the bus interface control and status block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import qbus_ctl_pkg::*;
  localparam logic [31:0] cfg_a = system_configuration_addr;
  localparam logic [31:0] err_a = dma_system_error_flags_addr;
  localparam logic [31:0] map_a = translation_map_base_addr;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  reg_req_t reg_req = '0;
  reg_rsp_t reg_rsp;
  logic io_reset_register = 1'b0, bus_bpok = 1'b1, bus_dcok = 1'b1, bus_bhalt = 1'b0;
  logic onboard_request = 1'b0, timer_request = 1'b0, iack_start = 1'b0;
  logic cyc_start = 1'b0, cyc_read = 1'b0, local_mem_error = 1'b0, bad_parity = 1'b0;
  logic [3:0] bus_request = 4'h0;
  logic [4:0] cpu_ipl = 5'h00;
  cyc_kind_t cyc_kind = cyc_demand;
  logic [15:0] grant_wait = 16'h0, reply_wait = 16'h0;
  logic bus_rply, bus_grant, cyc_reply, cyc_parity_err, bus_din, bus_iak, iack_done;
  logic cpu_halt, board_reset, soft_halt_line, cache_invalidate_all, mem_error_doorbell;
  logic [8:0] bus_vector, iack_vector;
  logic [2:0] iack_source;
  logic [4:0] ipl_after_ack;
  logic [1:0] halt_code;
  logic [31:0] map_base_out, rd;
  logic er, ci;
  int n_fail = 0;
  int n_compared = 0;
  // 125 MHz clock
  initial begin
    forever #4 mclk = ~mclk;
  end
  bus_partner partner (.mclk, .bus_din, .bus_iak, .cyc_start, .grant_wait, .reply_wait,
    .bad_parity, .vector(9'h0a4), .bus_rply, .bus_vector, .bus_grant, .cyc_reply,
    .cyc_parity_err);
  // short no-grant limit
  qbus_interface_control_status #(.no_grant_limit(50)) DUT (.mclk, .rstn, .reg_req, .reg_rsp,
    .io_reset_register, .bus_bpok, .bus_dcok, .bus_bhalt, .bus_request, .onboard_request,
    .timer_request, .cpu_ipl, .iack_start, .bus_rply, .bus_vector, .bus_din, .bus_iak,
    .iack_done, .iack_vector, .iack_source, .ipl_after_ack, .cyc_start, .cyc_kind, .cyc_read,
    .bus_grant, .cyc_reply, .cyc_parity_err, .local_mem_error, .cpu_halt, .board_reset,
    .soft_halt_line, .halt_code, .cache_invalidate_all, .mem_error_doorbell, .map_base_out);
  task automatic summarize();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask : chk
  // one-cycle request, answer one cycle later
  task automatic acc(input logic w, input logic [31:0] a, input logic [3:0] be,
                     input logic [31:0] d);
    @(posedge mclk);
    reg_req <= '{1'b1, w, a, be, d};
    @(posedge mclk);
    reg_req.valid <= 1'b0;
    #1;
    rd = reg_rsp.rdata;
    er = reg_rsp.error;
    ci = cache_invalidate_all;
    chk(reg_rsp.ack, 1, "ack");
  endtask : acc
  task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
    acc(1'b0, a, 4'hf, 32'h0);
    chk(rd, exp, "read");
  endtask : rdchk
  function automatic logic pick(input int s);
    case (s)
      0: return iack_done;
      1: return board_reset;
      2: return soft_halt_line;
      default: return cpu_halt;
    endcase
  endfunction : pick
  // bounded wait; running out ends the run
  task automatic waitfor(input int s, input int n);
    for (int i = 0; i < n; i++) begin
      #1;
      if (pick(s) === 1'b1) return;
      @(posedge mclk);
    end
    n_fail++;
    $display("unexpected at %0t: timeout %0d", $time, s);
    summarize();
  endtask : waitfor
  task automatic cyc(input cyc_kind_t k, input logic r, input logic [15:0] g,
                     input logic [15:0] w, input logic b, input int n);
    @(posedge mclk);
    cyc_kind <= k;
    cyc_read <= r;
    grant_wait <= g;
    reply_wait <= w;
    bad_parity <= b;
    cyc_start <= 1'b1;
    @(posedge mclk);
    cyc_start <= 1'b0;
    repeat (n) @(posedge mclk);
  endtask : cyc
  task automatic iack(input logic [3:0] br, input logic onb, input logic tmr,
                      input logic [2:0] src, input logic [4:0] ipl);
    @(posedge mclk);
    bus_request <= br;
    onboard_request <= onb;
    timer_request <= tmr;
    @(posedge mclk);
    iack_start <= 1'b1;
    @(posedge mclk);
    iack_start <= 1'b0;
    waitfor(0, 50);
    chk(iack_source, src, "source");
    chk(ipl_after_ack, ipl, "ipl");
    if (src[2]) chk(iack_vector, 9'h0a4, "vector");
  endtask : iack
  task automatic t_cfg();
    rdchk(cfg_a, 32'h8000);
    rdchk(err_a, 32'h0);
    bus_bpok <= 1'b0;
    repeat (4) @(posedge mclk);
    rdchk(cfg_a, 32'h0);
    bus_bpok <= 1'b1;
    acc(1'b1, cfg_a, 4'hf, 32'hffff_ffff);
    rdchk(cfg_a, 32'hc080);
    acc(1'b1, cfg_a, 4'h1, 32'h0);
    rdchk(cfg_a, 32'hc000);
    acc(1'b1, cfg_a, 4'h2, 32'h0);
    $display("cfg test done");
  endtask : t_cfg
  task automatic t_map();
    acc(1'b1, map_a, 4'hf, 32'h0fff_8000);
    chk(ci, 1, "flush");
    rdchk(map_a, 32'h0fff_8000);
    acc(1'b1, map_a, 4'h3, 32'h0);
    chk(er, 1, "partial");
    acc(1'b0, 32'h2008_0008, 4'hf, 32'h0);
    chk(er, 1, "unmapped");
    @(posedge mclk);
    io_reset_register <= 1'b1;
    @(posedge mclk);
    io_reset_register <= 1'b0;
    rdchk(map_a, 32'h0fff_8000);
    chk(map_base_out, 32'h0fff_8000, "map out");
    $display("map test done");
  endtask : t_map
  task automatic t_halt();
    acc(1'b1, cfg_a, 4'h2, 32'h4000);
    bus_bhalt <= 1'b1;
    waitfor(3, 5);
    bus_bhalt <= 1'b0;
    rdchk(err_a, 32'h8000);
    acc(1'b1, err_a, 4'h2, 32'h8000);
    rdchk(err_a, 32'h0);
    acc(1'b1, cfg_a, 4'h2, 32'h0);
    bus_bhalt <= 1'b1;
    repeat (4) @(posedge mclk);
    bus_bhalt <= 1'b0;
    rdchk(err_a, 32'h0);
    $display("halt test done");
  endtask : t_halt
  task automatic t_cycles();
    cyc(cyc_iack, 1'b1, 16'h2, 16'h0, 1'b0, 1300);
    rdchk(err_a, 32'h0);
    cyc(cyc_demand, 1'b0, 16'h2, 16'h0, 1'b0, 1300);
    rdchk(err_a, 32'h80);
    acc(1'b1, err_a, 4'h1, 32'h80);
    rdchk(err_a, 32'h0);
    cyc(cyc_request_read, 1'b1, 16'h2, 16'h3, 1'b1, 10);
    rdchk(err_a, 32'h0);
    cyc(cyc_demand, 1'b1, 16'h2, 16'h3, 1'b1, 10);
    rdchk(err_a, 32'h20);
    cyc(cyc_demand, 1'b1, 16'h2, 16'h3, 1'b1, 10);
    rdchk(err_a, 32'h28);
    acc(1'b1, err_a, 4'hf, 32'h0);
    rdchk(err_a, 32'h28);
    acc(1'b1, err_a, 4'hf, 32'h28);
    cyc(cyc_request_read, 1'b1, 16'h0, 16'h0, 1'b0, 80);
    rdchk(err_a, 32'h0);
    cyc(cyc_demand, 1'b1, 16'h0, 16'h0, 1'b0, 80);
    rdchk(err_a, 32'h4);
    local_mem_error <= 1'b1;
    @(posedge mclk);
    local_mem_error <= 1'b0;
    rdchk(err_a, 32'h14);
    chk(mem_error_doorbell, 1, "doorbell");
    io_reset_register <= 1'b1;
    @(posedge mclk);
    io_reset_register <= 1'b0;
    rdchk(err_a, 32'h0);
    $display("cycle test done");
  endtask : t_cycles
  task automatic t_dcok();
    acc(1'b1, cfg_a, 4'hf, 32'h4000);
    bus_dcok <= 1'b0;
    waitfor(1, 5);
    chk(halt_code, 2'h3, "code 3");
    bus_dcok <= 1'b1;
    repeat (10) @(posedge mclk);
    rdchk(cfg_a, 32'h8000);
    acc(1'b1, cfg_a, 4'hf, 32'h4080);
    bus_dcok <= 1'b0;
    waitfor(2, 5);
    chk(halt_code, 2'h2, "code 2");
    bus_dcok <= 1'b1;
    repeat (10) @(posedge mclk);
    rdchk(err_a, 32'h4000);
    rdchk(cfg_a, 32'hc080);
    $display("dcok test done");
  endtask : t_dcok
  // reset, then scenarios
  initial begin
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    repeat (2) @(posedge mclk);
    t_cfg();
    t_map();
    t_halt();
    t_cycles();
    iack(4'b0001, 1'b0, 1'b0, 3'h4, 5'h17);
    iack(4'b0001, 1'b1, 1'b0, 3'h2, 5'h14);
    iack(4'b0100, 1'b0, 1'b1, 3'h1, 5'h16);
    iack(4'b1000, 1'b0, 1'b1, 3'h7, 5'h17);
    $display("acknowledge test done");
    t_dcok();
    summarize();
  end
endmodule : testbench
bind qbus_interface_control_status qbus_ctl_props props (.mclk, .rstn, .reg_req, .reg_rsp,
  .bus_dcok, .local_mem_error, .bus_din, .bus_iak, .iack_done, .iack_source, .ipl_after_ack,
  .board_reset, .soft_halt_line, .halt_code, .cache_invalidate_all, .mem_error_doorbell,
  .map_base_out);
`default_nettype wire
